// [rpt_pkg.sv]
// Shared constants and types for the RGB panel link, both ends
package rpt_pkg;
	// Clock and data widths
	localparam int CLK_MHZ = 100;
	localparam int RGB_W   = 24;
	localparam int CNT_W   = 24;
	localparam int POS_W   = 11;

	// Reset input timing
	localparam int SPIKE_REJECT_NS      = 5000;
	localparam int RESET_PULSE_WIDTH_NS = 10000;
	localparam int SPIKE_REJECT_CYC     = (SPIKE_REJECT_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_PULSE_CYC      = (RESET_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;

	// Reset completion and command waits
	localparam int OTP_LOAD_US                    = 1000;
	localparam int RESET_COMPLETION_TIME_AWAKE_US = 120000;
	localparam int CMD_WAIT_US                    = 5000;
	localparam int SLEEP_OUT_WAIT_US              = 120000;
	localparam int OTP_LOAD_CYC                   = OTP_LOAD_US * CLK_MHZ;
	localparam int BLANK_CYC                      = RESET_COMPLETION_TIME_AWAKE_US * CLK_MHZ;
	localparam int CMD_WAIT_CYC                   = CMD_WAIT_US * CLK_MHZ;
	localparam int SLEEP_OUT_WAIT_CYC             = SLEEP_OUT_WAIT_US * CLK_MHZ;

	// Pixel clock divider, 25 MHz from 100 MHz
	localparam int PCLK_DIV = 4;

	// Line geometry in pixel clocks
	localparam int LINE_ACTIVE_PIXELS  = 480;
	localparam int LINE_SYNC_MIN       = 5;
	localparam int LINE_SYNC_MAX       = 80;
	localparam int LINE_SYNC_WIDTH_DEF = 10;
	localparam int LINE_BACK_PORCH_DEF = 30;
	localparam int LINE_FRONT_PORCH_DEF = 30;

	// Frame geometry in lines
	localparam int FRAME_ACTIVE_LINES    = 800;
	localparam int FRAME_SYNC_MIN        = 2;
	localparam int FRAME_SYNC_MAX        = 4;
	localparam int FRAME_SYNC_WIDTH_DEF  = 2;
	localparam int FRAME_BACK_PORCH_DEF  = 4;
	localparam int FRAME_FRONT_PORCH_DEF = 2;

	// Reset sequencer of the panel
	typedef enum logic [1:0] {
		RS_RUN   = 2'b00,
		RS_HELD  = 2'b01,
		RS_LOAD  = 2'b11,
		RS_BLANK = 2'b10
	} rpt_rst_state_e;
endpackage

// [rpt_link_if.sv]
// Parallel RGB video link with hardware reset between host and panel
`timescale 1ns/1ns
interface rpt_link_if;
	logic                     pclk;
	logic                     line_sync;
	logic                     frame_sync;
	logic                     pixel_valid_n;
	logic                     reset_n;
	logic [rpt_pkg::RGB_W-1:0] rgb;

	modport host (
		output pclk,
		output line_sync,
		output frame_sync,
		output pixel_valid_n,
		output reset_n,
		output rgb
	);
	modport panel (
		input pclk,
		input line_sync,
		input frame_sync,
		input pixel_valid_n,
		input reset_n,
		input rgb
	);
endinterface

// [rpt_panel.sv]
// Panel end: reset filter, settings reload, blanking and pixel capture
`timescale 1ns/1ns
module rpt_panel #(
	parameter int          LOAD_CYC           = rpt_pkg::OTP_LOAD_CYC,
	parameter int          BLANK_CYC          = rpt_pkg::BLANK_CYC,
	// Arbitrary identification value
	parameter logic [23:0] OTP_ID             = 24'h5a_a5_01,
	parameter logic [7:0]  OTP_COMMON_VOLTAGE = 8'h40
) (
	// Link from host
	rpt_link_if.panel                     lnk,
	// System clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// Sleep control, one-cycle pulses on clk
	input  wire logic                     sleep_out_cmd,
	input  wire logic                     sleep_in_cmd,
	// Status on clk
	output logic                          in_reset,
	output logic                          display_blank,
	output logic                          awake,
	output logic                          settings_loaded,
	output logic [23:0]                   id_bytes,
	output logic [7:0]                    common_voltage_setting,
	// Pixel side on the link clock
	output logic [rpt_pkg::RGB_W-1:0]     pix_data,
	output logic                          pix_strobe,
	output logic [rpt_pkg::POS_W-1:0]     pix_x,
	output logic [rpt_pkg::POS_W-1:0]     pix_y,
	output logic                          frame_start,
	output logic                          timing_error
);
	import rpt_pkg::*;

	logic           rn_s1;
	logic           rn_s2;
	logic           held;
	logic [15:0]    filt_cnt;
	rpt_rst_state_e state;
	rpt_rst_state_e next_state;
	logic [CNT_W-1:0] load_cnt;
	logic [CNT_W-1:0] blank_cnt;
	logic           blanking;
	logic           load_done;

	// Reset pin enters from the host side, two flops first
	always_ff @(posedge clk) begin
		if (rst) begin
			rn_s1 <= 1'b1;
			rn_s2 <= 1'b1;
		end else begin
			rn_s1 <= lnk.reset_n;
			rn_s2 <= rn_s1;
		end
	end

	// Symmetric filter: level must persist 5us to flip, in both directions
	always_ff @(posedge clk) begin
		if (rst) begin
			held     <= 1'b0;
			filt_cnt <= 16'h0000;
		end else if (rn_s2 != held) begin
			filt_cnt <= 16'h0000;
		end else if (filt_cnt == 16'(SPIKE_REJECT_CYC - 1)) begin
			held     <= ~held;
			filt_cnt <= 16'h0000;
		end else begin
			filt_cnt <= filt_cnt + 16'h0001;
		end
	end

	// Release is delayed by the filter time too; spikes inside a pulse are absorbed
	assign load_done = (load_cnt == CNT_W'(LOAD_CYC - 1));

	always_comb begin
		next_state = state;
		case (state)
			RS_RUN: begin
				if (held) begin
					next_state = RS_HELD;
				end
			end
			RS_HELD: begin
				if (!held) begin
					next_state = RS_LOAD;
				end
			end
			RS_LOAD: begin
				if (held) begin
					next_state = RS_HELD;
				end else if (load_done) begin
					next_state = blanking ? RS_BLANK : RS_RUN;
				end
			end
			RS_BLANK: begin
				if (held) begin
					next_state = RS_HELD;
				end else if (!blanking) begin
					next_state = RS_RUN;
				end
			end
			default: next_state = RS_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= RS_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Settings load timer runs only in the load state
	always_ff @(posedge clk) begin
		if (rst || state != RS_LOAD) begin
			load_cnt <= '0;
		end else if (!load_done) begin
			load_cnt <= load_cnt + CNT_W'(1);
		end
	end

	// Blanking sequence starts with the reset, only if the panel was awake
	always_ff @(posedge clk) begin
		if (rst) begin
			blanking  <= 1'b0;
			blank_cnt <= '0;
		end else if (state == RS_RUN && held && awake) begin
			blanking  <= 1'b1;
			blank_cnt <= '0;
		end else if (blanking) begin
			if (blank_cnt == CNT_W'(BLANK_CYC - 1)) begin
				blanking <= 1'b0;
			end
			blank_cnt <= blank_cnt + CNT_W'(1);
		end
	end

	// Commands are ignored until the panel is back in run
	always_ff @(posedge clk) begin
		if (rst) begin
			awake <= 1'b0;
		end else if (state != RS_RUN || held) begin
			awake <= 1'b0;
		end else if (sleep_out_cmd) begin
			awake <= 1'b1;
		end else if (sleep_in_cmd) begin
			awake <= 1'b0;
		end
	end

	// Settings are cleared on reset and reloaded once loading completes
	always_ff @(posedge clk) begin
		if (rst || state == RS_HELD) begin
			settings_loaded        <= 1'b0;
			id_bytes               <= 24'h000000;
			common_voltage_setting <= 8'h00;
		end else if (state == RS_LOAD && load_done) begin
			settings_loaded        <= 1'b1;
			id_bytes               <= OTP_ID;
			common_voltage_setting <= OTP_COMMON_VOLTAGE;
		end
	end

	// Asleep panel stays blank whatever the reset does
	always_ff @(posedge clk) begin
		if (rst) begin
			in_reset      <= 1'b1;
			display_blank <= 1'b1;
		end else begin
			in_reset      <= (next_state != RS_RUN);
			display_blank <= (next_state != RS_RUN) || !awake || blanking;
		end
	end

	// Link clock domain
	logic             bl_s1;
	logic             bl_s2;
	logic             ls_q;
	logic             fs_q;
	logic [POS_W-1:0] col;
	logic [POS_W-1:0] row;
	logic             line_px;
	logic [7:0]       ls_len;
	logic [3:0]       fs_lines;
	logic             sync_seen;
	logic             ls_fall;
	logic             ls_rise;
	logic             fs_fall;
	logic             fs_rise;

	// Blank level crosses as a level; it also resets the capture logic
	always_ff @(posedge lnk.pclk) begin
		bl_s1 <= display_blank;
		bl_s2 <= bl_s1;
	end

	// Link inputs are synchronous to the pixel clock
	assign ls_fall = ls_q && !lnk.line_sync;
	assign ls_rise = !ls_q && lnk.line_sync;
	assign fs_fall = fs_q && !lnk.frame_sync;
	assign fs_rise = !fs_q && lnk.frame_sync;

	always_ff @(posedge lnk.pclk) begin
		if (bl_s2) begin
			ls_q        <= 1'b1;
			fs_q        <= 1'b1;
			frame_start <= 1'b0;
		end else begin
			ls_q        <= lnk.line_sync;
			fs_q        <= lnk.frame_sync;
			frame_start <= fs_fall;
		end
	end

	// Pixels land only while valid is low
	always_ff @(posedge lnk.pclk) begin
		if (bl_s2) begin
			pix_strobe <= 1'b0;
			pix_data   <= '0;
			pix_x      <= '0;
			pix_y      <= '0;
		end else begin
			pix_strobe <= !lnk.pixel_valid_n;
			if (!lnk.pixel_valid_n) begin
				pix_data <= lnk.rgb;
				pix_x    <= col;
				pix_y    <= row;
			end
		end
	end

	// Position follows valid pixels, so porch lengths need not be known
	always_ff @(posedge lnk.pclk) begin
		if (bl_s2 || fs_fall) begin
			col     <= '0;
			row     <= '0;
			line_px <= 1'b0;
		end else begin
			if (ls_fall) begin
				col     <= '0;
				line_px <= 1'b0;
				if (line_px) begin
					row <= row + POS_W'(1);
				end
			end else if (!lnk.pixel_valid_n) begin
				col     <= col + POS_W'(1);
				line_px <= 1'b1;
			end
		end
	end

	// Sticky flag for sync widths outside their window
	always_ff @(posedge lnk.pclk) begin
		if (bl_s2) begin
			ls_len       <= 8'h00;
			fs_lines     <= 4'h0;
			sync_seen    <= 1'b0;
			timing_error <= 1'b0;
		end else begin
			// A sync already under way at blank release is partial, so judge only after a frame start
			if (fs_fall) begin
				sync_seen <= 1'b1;
			end
			if (!lnk.line_sync) begin
				ls_len <= (ls_len == 8'hff) ? ls_len : ls_len + 8'h01;
			end else begin
				ls_len <= 8'h00;
			end
			if (lnk.frame_sync) begin
				fs_lines <= 4'h0;
			end else if (ls_fall && fs_lines != 4'hf) begin
				fs_lines <= fs_lines + 4'h1;
			end
			if (sync_seen && ls_rise && (ls_len < 8'(LINE_SYNC_MIN) || ls_len > 8'(LINE_SYNC_MAX))) begin
				timing_error <= 1'b1;
			end
			if (sync_seen && fs_rise && (fs_lines < 4'(FRAME_SYNC_MIN) || fs_lines > 4'(FRAME_SYNC_MAX))) begin
				timing_error <= 1'b1;
			end
		end
	end
endmodule

// [rpt_host.sv]
// Host end: pixel clock divider, video timing generator and reset sequencer
`timescale 1ns/1ns
module rpt_host #(
	parameter int LSW        = rpt_pkg::LINE_SYNC_WIDTH_DEF,
	parameter int LBP        = rpt_pkg::LINE_BACK_PORCH_DEF,
	parameter int LFP        = rpt_pkg::LINE_FRONT_PORCH_DEF,
	parameter int FSW        = rpt_pkg::FRAME_SYNC_WIDTH_DEF,
	parameter int FBP        = rpt_pkg::FRAME_BACK_PORCH_DEF,
	parameter int FFP        = rpt_pkg::FRAME_FRONT_PORCH_DEF,
	parameter int CMD_WAIT   = rpt_pkg::CMD_WAIT_CYC,
	parameter int SLEEP_WAIT = rpt_pkg::SLEEP_OUT_WAIT_CYC
) (
	// Link to panel
	rpt_link_if.host                      lnk,
	// System clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// Panel reset request, one-cycle pulse
	input  wire logic                     reset_req,
	// Pixel source
	input  wire logic [rpt_pkg::RGB_W-1:0] pixel_rgb,
	output logic                          pixel_req,
	output logic [rpt_pkg::POS_W-1:0]     req_x,
	output logic [rpt_pkg::POS_W-1:0]     req_y,
	// Reset sequencing status
	output logic                          panel_reset_active,
	output logic                          cmd_allowed,
	output logic                          sleep_out_allowed
);
	import rpt_pkg::*;

	localparam int H_START = LSW + LBP;
	localparam int H_TOTAL = H_START + LINE_ACTIVE_PIXELS + LFP;
	localparam int V_START = FSW + FBP;
	localparam int V_TOTAL = V_START + FRAME_ACTIVE_LINES + FFP;

	logic [3:0]       div_cnt;
	logic [3:0]       next_div;
	logic             tick;
	logic             pclk_r;
	logic [POS_W-1:0] h;
	logic [POS_W-1:0] v;
	logic             active;
	logic             line_sync_r;
	logic             frame_sync_r;
	logic             valid_n_r;
	logic [RGB_W-1:0] rgb_r;
	logic             rst_n_r;
	logic [CNT_W-1:0] rcnt;

	// Host owns the pixel clock, so this is no second domain
	assign tick     = (div_cnt == 4'(PCLK_DIV - 1));
	assign next_div = tick ? 4'h0 : div_cnt + 4'h1;

	always_ff @(posedge clk) begin
		if (rst) begin
			div_cnt <= 4'h0;
			pclk_r  <= 1'b0;
		end else begin
			div_cnt <= next_div;
			pclk_r  <= (next_div >= 4'(PCLK_DIV / 2));
		end
	end

	// Outputs change as the pixel clock falls, centred for the panel's rising edge
	always_ff @(posedge clk) begin
		if (rst) begin
			h <= '0;
			v <= '0;
		end else if (tick) begin
			if (h == POS_W'(H_TOTAL - 1)) begin
				h <= '0;
				v <= (v == POS_W'(V_TOTAL - 1)) ? '0 : v + POS_W'(1);
			end else begin
				h <= h + POS_W'(1);
			end
		end
	end

	assign active = (h >= POS_W'(H_START)) && (h < POS_W'(H_START + LINE_ACTIVE_PIXELS)) &&
			(v >= POS_W'(V_START)) && (v < POS_W'(V_START + FRAME_ACTIVE_LINES));
	assign pixel_req = tick && active;
	assign req_x     = h - POS_W'(H_START);
	assign req_y     = v - POS_W'(V_START);

	always_ff @(posedge clk) begin
		if (rst) begin
			line_sync_r  <= 1'b1;
			frame_sync_r <= 1'b1;
			valid_n_r    <= 1'b1;
			rgb_r        <= '0;
		end else if (tick) begin
			line_sync_r  <= !(h < POS_W'(LSW));
			frame_sync_r <= !(v < POS_W'(FSW));
			valid_n_r    <= !active;
			rgb_r        <= active ? pixel_rgb : '0;
		end
	end

	// Reset pulse after power-on or on request, then the command waits
	always_ff @(posedge clk) begin
		if (rst || reset_req) begin
			rst_n_r           <= 1'b0;
			rcnt              <= '0;
			cmd_allowed       <= 1'b0;
			sleep_out_allowed <= 1'b0;
		end else if (!rst_n_r) begin
			if (rcnt == CNT_W'(RESET_PULSE_CYC - 1)) begin
				rst_n_r <= 1'b1;
				rcnt    <= '0;
			end else begin
				rcnt <= rcnt + CNT_W'(1);
			end
		end else if (!sleep_out_allowed) begin
			rcnt <= rcnt + CNT_W'(1);
			if (rcnt == CNT_W'(CMD_WAIT - 1)) begin
				cmd_allowed <= 1'b1;
			end
			if (rcnt == CNT_W'(SLEEP_WAIT - 1)) begin
				sleep_out_allowed <= 1'b1;
			end
		end
	end

	assign panel_reset_active = !rst_n_r;
	assign lnk.pclk           = pclk_r;
	assign lnk.line_sync      = line_sync_r;
	assign lnk.frame_sync     = frame_sync_r;
	assign lnk.pixel_valid_n  = valid_n_r;
	assign lnk.reset_n        = rst_n_r;
	assign lnk.rgb            = rgb_r;
endmodule

// [rpt_link_props.sv]
// Checker of video timing and reset on the host-to-panel link
`timescale 1ns/1ns
module rpt_link_props (
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      rst,
	// Link
	input wire logic                      pclk,
	input wire logic                      line_sync,
	input wire logic                      frame_sync,
	input wire logic                      pixel_valid_n,
	input wire logic                      reset_n,
	input wire logic [rpt_pkg::RGB_W-1:0] rgb
);
	import rpt_pkg::*;
	logic        pclk_q;
	logic        tick;
	logic        valid_q;
	logic [15:0] ls_low;
	logic [15:0] fs_lines;
	logic [15:0] act;
	logic [15:0] bp;
	logic [15:0] fp;
	logic [15:0] rn_low;
	// Link lines move at the pixel clock fall, so judge them at its rise
	assign tick = pclk && !pclk_q;
	always_ff @(posedge clk) begin
		pclk_q <= rst ? 1'b0 : pclk;
		rn_low <= (rst || reset_n) ? 16'h0 : rn_low + 16'h1;
	end
	// Counters in pixel clocks, fs_lines in lines; front porch may run long in blank lines but is only read after a live line
	always_ff @(posedge clk) begin
		if (rst) begin
			valid_q  <= 1'b1;
			ls_low   <= 16'h0;
			fs_lines <= 16'h0;
			act      <= 16'h0;
			bp       <= 16'h0;
			fp       <= 16'h0;
		end else if (tick) begin
			valid_q  <= pixel_valid_n;
			ls_low   <= line_sync ? 16'h0 : ls_low + 16'h1;
			fs_lines <= frame_sync ? 16'h0 : fs_lines + {15'h0, !line_sync && ls_low == 16'h0};
			act      <= !line_sync ? 16'h0 : act + {15'h0, !pixel_valid_n};
			bp       <= !line_sync ? 16'h0 : bp + {15'h0, pixel_valid_n && act == 16'h0};
			fp       <= !pixel_valid_n ? 16'h0 : fp + 16'h1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence line_start;
		tick && !line_sync && ls_low == 16'h0;
	endsequence
	sequence line_had_pixels;
		line_start ##0 act != 16'h0;
	endsequence
	sequence first_pixel;
		tick && !pixel_valid_n && valid_q;
	endsequence
	sequence reset_held;
		!reset_n [*8];
	endsequence
	AST_LINE_SYNC_MIN: assert property (tick && line_sync && ls_low != 16'h0 |-> ls_low >= 16'h5)
		else $error("line sync low too short");
	AST_LINE_SYNC_MAX: assert property (tick |-> ls_low <= 16'h50)
		else $error("line sync low too long");
	AST_FRAME_SYNC_LINES: assert property (tick && frame_sync && fs_lines != 16'h0 |-> fs_lines inside {[16'h2:16'h4]})
		else $error("frame sync line count out of range");
	AST_ACTIVE_PIXELS: assert property (line_had_pixels |-> act == 16'h1e0)
		else $error("active pixel count wrong");
	AST_BACK_PORCH: assert property (first_pixel |-> bp inside {[16'ha:16'h55]})
		else $error("line back porch out of range");
	AST_FRONT_PORCH: assert property (line_had_pixels |-> fp inside {[16'h5:16'h50]})
		else $error("line front porch out of range");
	AST_PORCH_SUM: assert property (line_had_pixels |-> bp + fp inside {[16'h3c:16'h5a]})
		else $error("line blanking out of range");
	AST_VALID_IN_SYNC: assert property (tick && !pixel_valid_n |-> line_sync && frame_sync)
		else $error("pixel valid during sync");
	AST_IDLE_DATA: assert property (tick && pixel_valid_n |-> rgb == {RGB_W{1'b0}})
		else $error("pixel data while not valid");
	AST_RESET_WIDTH: assert property ($rose(reset_n) |-> rn_low >= 16'h3e8)
		else $error("panel reset pulse too short");
	AST_POWER_ON_RESET: assert property ($fell(rst) |-> reset_held)
		else $error("no panel reset after power-on");
endmodule

// [tb.sv]
// Testbench: host and panel on one link, a bench-driven panel on another
`timescale 1ns/1ns
module tb;
	import rpt_pkg::*;
	localparam int          LOAD  = 20;
	localparam int          BLANK = 100;
	localparam int          CWAIT = 50;
	localparam int          SWAIT = 200;
	// Arbitrary identification and voltage values
	localparam logic [23:0] ID    = 24'h3c_c3_07;
	localparam logic [7:0]  CV    = 8'h2a;
	logic             clk = 1'b0, rst = 1'b1, reset_req = 1'b0, sleep_out_cmd = 1'b0, sleep_in_cmd = 1'b0;
	logic             pixel_req, panel_reset_active, cmd_allowed, sleep_out_allowed, pix_strobe, timing_error;
	logic             in_reset, display_blank, awake, settings_loaded, in_reset2, loaded2;
	logic [RGB_W-1:0] pixel_rgb, pix_data;
	logic [POS_W-1:0] req_x, req_y, pix_x, pix_y;
	logic [23:0]      id_bytes;
	logic [7:0]       common_voltage_setting;
	int               err_count = 0, checks = 0, exp_x = 0, line_cnt = 0;
	logic             check_on = 1'b0;
	rpt_link_if lnk_i();
	rpt_link_if lnk2();
	// Pixel value carries its own position so the panel side can be judged
	assign pixel_rgb = {2'h0, req_y, req_x};
	rpt_host #(.CMD_WAIT(CWAIT), .SLEEP_WAIT(SWAIT)) rpt_host_i (.lnk(lnk_i), .clk, .rst, .reset_req, .pixel_rgb,
		.pixel_req, .req_x, .req_y, .panel_reset_active, .cmd_allowed, .sleep_out_allowed);
	rpt_panel #(.LOAD_CYC(LOAD), .BLANK_CYC(BLANK), .OTP_ID(ID), .OTP_COMMON_VOLTAGE(CV)) rpt_panel_i (.lnk(lnk_i),
		.clk, .rst, .sleep_out_cmd, .sleep_in_cmd, .in_reset, .display_blank, .awake, .settings_loaded, .id_bytes,
		.common_voltage_setting, .pix_data, .pix_strobe, .pix_x, .pix_y, .frame_start(), .timing_error);
	rpt_panel #(.LOAD_CYC(LOAD), .BLANK_CYC(BLANK)) rpt_panel_i2 (.lnk(lnk2), .clk, .rst, .sleep_out_cmd(1'b0),
		.sleep_in_cmd(1'b0), .in_reset(in_reset2), .display_blank(), .awake(), .settings_loaded(loaded2), .id_bytes(),
		.common_voltage_setting(), .pix_data(), .pix_strobe(), .pix_x(), .pix_y(), .frame_start(), .timing_error());
	rpt_link_props rpt_link_props_i (.clk, .rst, .pclk(lnk_i.pclk), .line_sync(lnk_i.line_sync),
		.frame_sync(lnk_i.frame_sync), .pixel_valid_n(lnk_i.pixel_valid_n), .reset_n(lnk_i.reset_n), .rgb(lnk_i.rgb));
	always #5 clk = ~clk;
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check_bit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	function automatic logic sel(input int which);
		case (which)
			0: return cmd_allowed;
			1: return sleep_out_allowed;
			2: return in_reset;
			3: return lnk_i.reset_n;
			default: return in_reset2;
		endcase
	endfunction
	task automatic wait_for(input int which, input logic lvl, input int lim, output int n);
		n = 0;
		while (sel(which) !== lvl && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	// Pixel side judged just after the pixel clock rise, when panel outputs have settled
	always @(posedge lnk_i.pclk) begin
		#1;
		if (check_on && !lnk_i.line_sync && exp_x != 0) begin
			check_val("pixels in line", 480, exp_x);
			line_cnt++;
			exp_x = 0;
		end
		if (check_on && pix_strobe === 1'b1) begin
			check_val("pixel x", exp_x, pix_x);
			check_val("pixel y", line_cnt, pix_y);
			check_val("pixel data", {2'h0, 11'(line_cnt), 11'(exp_x)}, pix_data);
			exp_x++;
		end
	end
	task automatic s_power_up();
		int n, m, k;
		check_bit("reset_n at power-on", 1'b0, lnk_i.reset_n);
		wait_for(3, 1'b1, 1200, n);
		check_bit("in reset before release", 1'b1, in_reset);
		check_bit("settings before release", 1'b0, settings_loaded);
		wait_for(0, 1'b1, 300, n);
		check_bit("command wait", 1'b1, n + 2 >= CWAIT && n <= CWAIT + 2);
		wait_for(1, 1'b1, 400, m);
		check_bit("sleep out wait", 1'b1, n + m + 2 >= SWAIT && n + m <= SWAIT + 2);
		wait_for(2, 1'b0, 800, k);
		check_bit("asleep completion", 1'b1, n + m + k >= 500 && n + m + k <= 513 + LOAD);
		check_bit("settings loaded", 1'b1, settings_loaded);
		check_val("id bytes", ID, id_bytes);
		check_val("voltage setting", CV, common_voltage_setting);
		check_bit("blank while asleep", 1'b1, display_blank);
		check_bit("awake after reset", 1'b0, awake);
	endtask
	task automatic s_wake_pixels();
		int n;
		tick(4000);
		sleep_out_cmd = 1'b1;
		tick(1);
		sleep_out_cmd = 1'b0;
		tick(4);
		check_bit("awake", 1'b1, awake);
		check_bit("display blank", 1'b0, display_blank);
		check_on = 1'b1;
		n = 0;
		while (line_cnt < 3 && n < 30000) begin
			tick(1);
			n++;
		end
		check_on = 1'b0;
		check_bit("lines captured", 1'b1, line_cnt >= 3);
		check_bit("timing error", 1'b0, timing_error);
	endtask
	task automatic s_awake_reset();
		int n;
		reset_req = 1'b1;
		tick(1);
		reset_req = 1'b0;
		check_bit("host reset out", 1'b1, panel_reset_active);
		wait_for(2, 1'b1, 700, n);
		check_bit("reset entry", 1'b1, n >= 490 && n <= 510);
		check_bit("blank in reset", 1'b1, display_blank);
		check_bit("awake in reset", 1'b0, awake);
		wait_for(2, 1'b0, 2500, n);
		check_bit("awake completion", 1'b1, n >= 1000 && n <= 1020 + LOAD + BLANK);
		check_bit("reload", 1'b1, settings_loaded);
		check_bit("default blank", 1'b1, display_blank);
		check_bit("default asleep", 1'b0, awake);
	endtask
	// Spikes come from the bench, since the host only makes legal pulses
	task automatic s_spikes();
		int n;
		lnk2.reset_n = 1'b0;
		tick(400);
		lnk2.reset_n = 1'b1;
		tick(600);
		check_bit("short low ignored", 1'b0, in_reset2);
		lnk2.reset_n = 1'b0;
		tick(950);
		check_bit("long low taken", 1'b1, in_reset2);
		lnk2.reset_n = 1'b1;
		tick(200);
		lnk2.reset_n = 1'b0;
		tick(400);
		check_bit("spike in pulse", 1'b1, in_reset2);
		check_bit("no reload on spike", 1'b0, loaded2);
		lnk2.reset_n = 1'b1;
		wait_for(4, 1'b0, 800, n);
		check_bit("release filtered", 1'b1, n >= 500 && n <= 513 + LOAD);
		check_bit("reload after release", 1'b1, loaded2);
	endtask
	task automatic print_verdict();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		lnk2.pclk = 1'b0;
		lnk2.line_sync = 1'b1;
		lnk2.frame_sync = 1'b1;
		lnk2.pixel_valid_n = 1'b1;
		lnk2.reset_n = 1'b1;
		lnk2.rgb = {RGB_W{1'b0}};
		tick(12);
		rst = 1'b0;
		tick(1);
		s_power_up();
		s_wake_pixels();
		s_awake_reset();
		s_spikes();
		print_verdict();
	end
	initial begin
		#1000000;
		err_count++;
		$display("wrong value watchdog expected finish seen timeout");
		print_verdict();
	end
endmodule
